// file: dcc_periph_model.sv
// Peripheral requesters facing the channel request and acknowledge pins.
// Assumes the bench tells it the polarities that it programmed.
`timescale 1ns/10ps
module dcc_periph_model (
	// Clock and reset
	input wire logic	pclk,
	input wire logic	presetn,
	// Bench control
	input wire logic [3:0]	want,
	input wire logic [3:0]	shot,
	input wire logic	req_low,
	input wire logic	ack_high,
	// Device pins
	input wire logic [3:0]	ack,
	output logic [3:0]	req
);
	logic [3:0]	pend_q;
	logic [3:0]	ack_act;
	assign ack_act = ack_high ? ack : ~ack;
	// One-shot request held until its acknowledge shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pend_q <= 4'h0;
		else
			pend_q <= (pend_q | shot) & ~ack_act;
	end
	assign req = (want | pend_q) ^ {4{req_low}};
endmodule

// file: dcc_pkg.sv
// Constants, register map and carrier types of the DMA channel control block.
// Assumes a 32-bit APB register port with an 8-bit byte address.
package dcc_pkg;

	localparam int NUM_CH   = 4;
	localparam int CH_W     = 2;
	localparam int ADDR_W   = 16;
	localparam int PADDR_W  = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_CMD     = 8'h00;
	localparam logic [7:0] OFS_MODE    = 8'h04;
	localparam logic [7:0] OFS_MCLR    = 8'h08;
	localparam logic [7:0] OFS_MASK    = 8'h0C;
	localparam logic [7:0] OFS_STATUS  = 8'h10;
	localparam logic [7:0] OFS_TEMP    = 8'h14;
	localparam logic [7:0] OFS_ADDR0   = 8'h20;
	localparam logic [7:0] OFS_CNT0    = 8'h30;
	localparam logic [7:0] OFS_GRP_MSK = 8'hF0;
	localparam logic [1:0] IDX_LSB     = 2;

	// Reset values
	localparam logic [7:0]        CMD_RST  = 8'h00;
	localparam logic [NUM_CH-1:0] MASK_RST = 4'hF;
	localparam logic [7:0]        TEMP_RST = 8'h00;

	// Last cycle index of a transfer, one less than its length in clock cycles
	localparam logic [1:0] NORM_CYC = 2'd3;
	localparam logic [1:0] COMP_CYC = 2'd1;

	// Transfer mode and direction codes
	localparam logic [1:0] XM_DEMAND = 2'h0;
	localparam logic [1:0] XM_SINGLE = 2'h1;
	localparam logic [1:0] XM_BLOCK  = 2'h2;
	localparam logic [1:0] DIR_VERIFY = 2'h0;
	localparam logic [1:0] DIR_TO_MEM = 2'h1;
	localparam logic [1:0] DIR_FROM_MEM = 2'h2;

	typedef struct packed {
		logic ack_high;     // bit 7
		logic req_low;      // bit 6
		logic write_strobe_select;
		logic priority_scheme_select;
		logic compressed;   // bit 3
		logic disable_ctl;  // bit 2
		logic ch0_hold;     // bit 1
		logic mem_to_mem;   // bit 0
	} dcc_cmd_s;

	typedef struct packed {
		logic [1:0] xfer_mode;   // bits 7-6
		logic       address_step_direction;
		logic       auto_init;   // bit 4
		logic [1:0] dir;         // bits 3-2
	} dcc_mode_s;

	typedef struct packed {
		logic mem_rd;
		logic mem_wr;
		logic io_rd;
		logic io_wr;
	} dcc_strb_s;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_XFER    = 3'b010,
		ST_RELEASE = 3'b100
	} dcc_state_e;

endpackage

// file: dcc_top.sv
// Four-channel byte DMA channel control: command and mode registers,
// channel arbitration, transfer sequencing and address/count stepping.
// Assumes an APB master, asynchronous pin inputs for requests and
// end-of-process, and memory read data on the same clock.
//
// How it works
// - Reset and master clear both zero the command register.
// - Command bit 6 set makes request active low; bit 7 clear, ack low.
// - Timing bit picks normal or compressed two-cycle transfers.
// - Write select picks late or extended write strobes.
// - Priority bit zero gives fixed order, channel zero first.
// - Rotating priority puts the last serviced channel lowest.
// - Disable bit keeps an idle controller from starting; writing zero re-enables.
// - Command bit 1 keeps channel zero address constant.
// - Memory-to-memory copies channel zero to channel one via temp register.
// - Mode write applies only to channel in its select field.
// - Mode field: demand 0, single 1, block 2, cascade 3 unused.
// - Single mode does one transfer then releases the bus.
// - Terminal count when count wraps zero to all ones; then auto-init.
// - Block mode runs until terminal count or end of process.
// - Demand mode suspends while request drops, resumes when raised.
// - Address increments when direction bit zero, decrements when one.
// - Auto-init reloads current from base; transfers never touch base.
// - Direction 1 into memory, 2 out of memory, 0 verify only.
// - Writing current address or count also writes its base register.
// - End of process without auto-init sets that channel's mask bit.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps

module dcc_top (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [dcc_pkg::PADDR_W-1:0]   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Peripheral handshake
	input  wire logic [dcc_pkg::NUM_CH-1:0]    channel_request_line,
	output logic      [dcc_pkg::NUM_CH-1:0]    channel_acknowledge_line,
	input  wire logic                          end_of_process_n,
	// Memory side
	input  wire logic [7:0]                    mem_rdata,
	output logic      [7:0]                    mem_wdata,
	output logic      [dcc_pkg::ADDR_W-1:0]    dma_addr,
	output dcc_pkg::dcc_strb_s                 strobes,
	output logic                               bus_hold,
	output logic                               terminal_count
);
	import dcc_pkg::*;

	function automatic logic [NUM_CH-1:0] chan_bit(input logic [CH_W-1:0] c);
		chan_bit = 4'h1 << c;
	endfunction

	// First eligible channel at or after base, wrapping
	function automatic logic [CH_W-1:0] pick(input logic [NUM_CH-1:0] r,
		input logic [CH_W-1:0] base);
		logic [CH_W-1:0] c;
		pick = base;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			c = base + CH_W'(i);
			if (r[c])
				pick = c;
		end
	endfunction

	function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
		input logic dec);
		step = dec ? a - 16'h0001 : a + 16'h0001;
	endfunction

	// Input synchronisers
	logic [NUM_CH-1:0] req_s1_q, req_s2_q;
	logic              eop_s1_q, eop_s2_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_s1_q <= 4'h0;
			req_s2_q <= 4'h0;
			eop_s1_q <= 1'b1;
			eop_s2_q <= 1'b1;
		end else begin
			req_s1_q <= channel_request_line;
			req_s2_q <= req_s1_q;
			eop_s1_q <= end_of_process_n;
			eop_s2_q <= eop_s1_q;
		end
	end

	// Register state
	dcc_cmd_s          cmd_q;
	dcc_mode_s         mode_q [NUM_CH];
	logic [ADDR_W-1:0] cur_addr_q [NUM_CH];
	logic [ADDR_W-1:0] cur_cnt_q  [NUM_CH];
	logic [ADDR_W-1:0] base_addr_q[NUM_CH];
	logic [ADDR_W-1:0] base_cnt_q [NUM_CH];
	logic [NUM_CH-1:0] mask_q;
	logic [NUM_CH-1:0] tc_flag_q;
	logic [7:0]        temp_q;

	// Sequencer state
	dcc_state_e        state_q;
	logic [CH_W-1:0]   ch_q;
	logic [CH_W-1:0]   last_q;
	logic [1:0]        cyc_q;
	logic              m2m_q;
	logic              phase_q;
	logic              eop_seen_q;

	// APB decode
	logic              acc, wr_en, rd_en, idx_hit;
	logic [CH_W-1:0]   idx;
	logic [7:0]        grp;

	assign acc     = psel & penable;
	assign wr_en   = acc & pready & pwrite;
	assign rd_en   = acc & pready & ~pwrite;
	assign idx     = paddr[IDX_LSB +: CH_W];
	assign grp     = paddr & OFS_GRP_MSK;
	assign idx_hit = (paddr[1:0] == 2'b00);

	logic wr_cmd, wr_mode, wr_mclr, wr_mask, wr_addr, wr_cnt, rd_stat;
	assign wr_cmd  = wr_en && paddr == OFS_CMD;
	assign wr_mode = wr_en && paddr == OFS_MODE;
	assign wr_mclr = wr_en && paddr == OFS_MCLR;
	assign wr_mask = wr_en && paddr == OFS_MASK;
	assign wr_addr = wr_en && idx_hit && grp == OFS_ADDR0;
	assign wr_cnt  = wr_en && idx_hit && grp == OFS_CNT0;
	assign rd_stat = rd_en && paddr == OFS_STATUS;

	// Arbitration
	logic [NUM_CH-1:0] req_act, eligible;
	logic [CH_W-1:0]   grant;
	logic [1:0]        len;
	logic              last_cyc;
	logic [CH_W-1:0]   cnt_ch;
	logic              tc_hit, done;

	assign req_act  = cmd_q.req_low ? ~req_s2_q : req_s2_q;
	assign eligible = req_act & ~mask_q;
	assign grant    = pick(eligible, cmd_q.priority_scheme_select ?
		last_q + 2'd1 : 2'd0);
	assign len      = cmd_q.compressed ? COMP_CYC : NORM_CYC;
	assign last_cyc = state_q == ST_XFER && cyc_q == len;
	assign cnt_ch   = m2m_q ? 2'd1 : ch_q;
	assign tc_hit   = cur_cnt_q[cnt_ch] == 16'h0000;
	// One transfer finishes at the end of its final cycle
	logic step_en;
	assign step_en  = last_cyc && (!m2m_q || phase_q);
	assign done     = step_en && (tc_hit || eop_seen_q || !eop_s2_q);

	// APB answer: one wait state, then registered data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc & ~pready;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			if (acc && !pready) begin
				if (grp == OFS_ADDR0 && idx_hit)
					prdata <= {16'h0000, cur_addr_q[idx]};
				else if (grp == OFS_CNT0 && idx_hit)
					prdata <= {16'h0000, cur_cnt_q[idx]};
				else if (paddr == OFS_MASK)
					prdata <= {28'h0000000, mask_q};
				else if (paddr == OFS_STATUS && !pwrite)
					prdata <= {24'h000000, req_act, tc_flag_q};
				else if (paddr == OFS_TEMP && !pwrite)
					prdata <= {24'h000000, temp_q};
				else if (!(pwrite && (paddr == OFS_CMD ||
					paddr == OFS_MODE || paddr == OFS_MCLR)))
					pslverr <= 1'b1;
			end
		end
	end

	// Command register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd_q <= CMD_RST;
		else if (wr_mclr)
			cmd_q <= CMD_RST;
		else if (wr_cmd)
			cmd_q <= pwdata[7:0];
	end

	// Mode registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CH; i++)
				mode_q[i] <= '0;
		end else if (wr_mode) begin
			mode_q[pwdata[1:0]] <= pwdata[7:2];
		end
	end

	// Channel address, count and base registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				cur_addr_q[i]  <= 16'h0000;
				cur_cnt_q[i]   <= 16'h0000;
				base_addr_q[i] <= 16'h0000;
				base_cnt_q[i]  <= 16'h0000;
			end
		end else begin
			if (step_en) begin
				// Channel zero source address in memory-to-memory
				if (m2m_q && !cmd_q.ch0_hold)
					cur_addr_q[0] <= step(cur_addr_q[0],
						mode_q[0].address_step_direction);
				if (!(ch_q == 2'd0 && cmd_q.ch0_hold) || m2m_q)
					cur_addr_q[cnt_ch] <= step(cur_addr_q[cnt_ch],
						mode_q[cnt_ch].address_step_direction);
				cur_cnt_q[cnt_ch] <= cur_cnt_q[cnt_ch] - 16'h0001;
				if (done && mode_q[cnt_ch].auto_init) begin
					cur_addr_q[cnt_ch] <= base_addr_q[cnt_ch];
					cur_cnt_q[cnt_ch]  <= base_cnt_q[cnt_ch];
					if (m2m_q && mode_q[0].auto_init)
						cur_addr_q[0] <= base_addr_q[0];
				end
			end
			if (wr_addr) begin
				cur_addr_q[idx]  <= pwdata[ADDR_W-1:0];
				base_addr_q[idx] <= pwdata[ADDR_W-1:0];
			end
			if (wr_cnt) begin
				cur_cnt_q[idx]  <= pwdata[ADDR_W-1:0];
				base_cnt_q[idx] <= pwdata[ADDR_W-1:0];
			end
		end
	end

	// Mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_q <= MASK_RST;
		else if (done && !mode_q[cnt_ch].auto_init)
			mask_q <= (wr_mask ? pwdata[NUM_CH-1:0] : mask_q) |
				chan_bit(cnt_ch);
		else if (wr_mclr)
			mask_q <= MASK_RST;
		else if (wr_mask)
			mask_q <= pwdata[NUM_CH-1:0];
	end

	// Terminal count flags, cleared by status read; set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tc_flag_q <= 4'h0;
		else
			tc_flag_q <= (tc_flag_q & ~{NUM_CH{rd_stat | wr_mclr}}) |
				(done ? chan_bit(cnt_ch) : 4'h0);
	end

	// Temporary register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			temp_q <= TEMP_RST;
		else if (wr_mclr)
			temp_q <= TEMP_RST;
		else if (last_cyc && m2m_q && !phase_q)
			temp_q <= mem_rdata;
	end

	// Transfer sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_IDLE;
			ch_q       <= 2'd0;
			last_q     <= 2'd3;
			cyc_q      <= 2'd0;
			m2m_q      <= 1'b0;
			phase_q    <= 1'b0;
			eop_seen_q <= 1'b0;
		end else if (wr_mclr) begin
			state_q    <= ST_IDLE;
			cyc_q      <= 2'd0;
			m2m_q      <= 1'b0;
			phase_q    <= 1'b0;
			eop_seen_q <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				eop_seen_q <= 1'b0;
				if (!cmd_q.disable_ctl && |eligible) begin
					state_q <= ST_XFER;
					ch_q    <= grant;
					cyc_q   <= 2'd0;
					m2m_q   <= cmd_q.mem_to_mem && grant == 2'd0;
					phase_q <= 1'b0;
				end
			end
			ST_XFER: begin
				cyc_q <= cyc_q + 2'd1;
				if (!eop_s2_q)
					eop_seen_q <= 1'b1;
				if (last_cyc) begin
					cyc_q <= 2'd0;
					if (m2m_q && !phase_q) begin
						phase_q <= 1'b1;
					end else begin
						phase_q <= 1'b0;
						last_q  <= ch_q;
						if (done)
							state_q <= ST_IDLE;
						else if (m2m_q)
							state_q <= ST_XFER;
						else
							case (mode_q[ch_q].xfer_mode)
							XM_SINGLE: state_q <= ST_RELEASE;
							XM_BLOCK:  state_q <= ST_XFER;
							XM_DEMAND: state_q <= req_act[ch_q] ?
								ST_XFER : ST_IDLE;
							default:   state_q <= ST_IDLE;
							endcase
					end
				end
			end
			ST_RELEASE: state_q <= ST_IDLE;
			default:    state_q <= ST_IDLE;
			endcase
		end
	end

	// Registered bus outputs
	logic xfer, wr_win;
	assign xfer   = state_q == ST_XFER;
	assign wr_win = xfer && (cmd_q.write_strobe_select || cyc_q == len);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_acknowledge_line <= 4'hF;
			dma_addr       <= 16'h0000;
			strobes        <= '0;
			bus_hold       <= 1'b0;
			terminal_count <= 1'b0;
			mem_wdata      <= 8'h00;
		end else begin
			channel_acknowledge_line <= (xfer && !m2m_q ? chan_bit(ch_q) :
				4'h0) ^ {NUM_CH{~cmd_q.ack_high}};
			dma_addr       <= m2m_q && !phase_q ? cur_addr_q[0] :
				cur_addr_q[cnt_ch];
			bus_hold       <= xfer;
			terminal_count <= done && tc_hit;
			mem_wdata      <= temp_q;
			strobes        <= '0;
			if (m2m_q) begin
				strobes.mem_rd <= xfer && !phase_q;
				strobes.mem_wr <= wr_win && phase_q;
			end else begin
				case (mode_q[ch_q].dir)
				DIR_TO_MEM: begin
					strobes.io_rd  <= xfer;
					strobes.mem_wr <= wr_win;
				end
				DIR_FROM_MEM: begin
					strobes.mem_rd <= xfer;
					strobes.io_wr  <= wr_win;
				end
				DIR_VERIFY: strobes <= '0;
				default:    strobes <= '0;
				endcase
			end
		end
	end

endmodule

// file: dcc_top_asserts.sv
// Checker for dcc_top: APB answer, ack polarity, strobe shapes.
// Assumes command writes arrive over APB and are mirrored here.
`timescale 1ns/10ps
module dcc_top_asserts (
	// Clock and reset
	input wire logic			pclk,
	input wire logic			presetn,
	// APB
	input wire logic			psel,
	input wire logic			penable,
	input wire logic			pwrite,
	input wire logic [dcc_pkg::PADDR_W-1:0]	paddr,
	input wire logic [31:0]			pwdata,
	input wire logic			pready,
	input wire logic			pslverr,
	// Transfer side
	input wire logic [dcc_pkg::NUM_CH-1:0]	channel_acknowledge_line,
	input wire dcc_pkg::dcc_strb_s		strobes,
	input wire logic			bus_hold,
	input wire logic			terminal_count
);
	import dcc_pkg::*;
	dcc_cmd_s	cmd_q;
	dcc_cmd_s	cmd_p_q;
	logic [1:0]	dis_q;
	logic [3:0]	ack_act;
	logic		rd_s;
	logic		wr_s;
	logic		cmd_ok;
	logic		wr_go;
	assign wr_go = psel && penable && pready && pwrite;
	assign ack_act = cmd_q.ack_high ? channel_acknowledge_line :
		~channel_acknowledge_line;
	assign rd_s = strobes.mem_rd || strobes.io_rd;
	assign wr_s = strobes.mem_wr || strobes.io_wr;
	assign cmd_ok = (cmd_q == cmd_p_q);
	// Mirror of the command register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= dcc_cmd_s'(CMD_RST);
			cmd_p_q <= dcc_cmd_s'(CMD_RST);
		end else begin
			cmd_p_q <= cmd_q;
			if (wr_go && paddr == OFS_CMD)
				cmd_q <= dcc_cmd_s'(pwdata[7:0]);
			else if (wr_go && paddr == OFS_MCLR)
				cmd_q <= dcc_cmd_s'(CMD_RST);
		end
	end
	// Cycles since disable was set, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dis_q <= 2'h0;
		else if (!cmd_q.disable_ctl)
			dis_q <= 2'h0;
		else if (dis_q != 2'h3)
			dis_q <= dis_q + 2'h1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence rd_held4; rd_s [*4]; endsequence
	sequence rd_held2; rd_s [*2]; endsequence
	sequence wr_held2; wr_s [*2]; endsequence
	apb_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("APB access not answered after one wait state");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("Slave error without ready");
	ack_onehot_a: assert property (cmd_ok |-> $onehot0(ack_act))
		else $error("More than one acknowledge active");
	ack_hold_a: assert property (cmd_ok && ack_act != 0 |-> bus_hold)
		else $error("Acknowledge active outside a transfer");
	disabled_idle_a: assert property (dis_q == 2'h3 && !bus_hold |=> !bus_hold)
		else $error("Transfer started while disabled");
	normal_len_a: assert property ($rose(rd_s) && !cmd_q.compressed && cmd_ok |-> rd_held4)
		else $error("Normal transfer shorter than four cycles");
	comp_len_a: assert property ($rose(rd_s) && cmd_q.compressed |-> rd_held2)
		else $error("Compressed transfer shorter than two cycles");
	late_write_a: assert property (wr_s && !cmd_q.write_strobe_select && cmd_ok |=> !wr_s)
		else $error("Late write strobe longer than one cycle");
	ext_write_a: assert property ($rose(wr_s) && cmd_q.write_strobe_select |-> wr_held2)
		else $error("Extended write strobe too short");
	idle_strobes_a: assert property (!bus_hold |-> strobes == '0)
		else $error("Strobe active with bus released");
	tc_pulse_a: assert property (terminal_count |=> !terminal_count)
		else $error("Terminal count longer than one cycle");
endmodule
bind dcc_top dcc_top_asserts chk_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .channel_acknowledge_line,
	.strobes, .bus_hold, .terminal_count);

// file: test_dma_channel_control.sv
// Self-checking bench for dcc_top against an integer channel model.
// Assumes the peripheral model and checker files are compiled first.
`timescale 1ns/10ps
module test_dma_channel_control;
	import dcc_pkg::*;
	logic		pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]	paddr = 0, mem_rdata = 0, mem_wdata;
	logic [31:0]	pwdata = 0, prdata, r;
	logic		pready, pslverr, bus_hold, terminal_count, e, hold_p = 0;
	logic [3:0]	req, ack, want = 0, shot = 0;
	logic		reql = 0, ackh = 0, eopn = 1;
	logic [15:0]	dma_addr;
	dcc_strb_s	strobes;
	int		fails = 0, compares = 0, rises, tcs, wrc, rdl, run, first;
	int		ca[4], cc[4], ba[4], bc[4], msk = 15;
	int		iow, wa, ra;
	always #5 pclk = ~pclk;
	dcc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .channel_request_line(req),
		.channel_acknowledge_line(ack), .end_of_process_n(eopn),
		.mem_rdata, .mem_wdata, .dma_addr, .strobes, .bus_hold,
		.terminal_count);
	dcc_periph_model peer (.pclk, .presetn, .want, .shot, .req_low(reql),
		.ack_high(ackh), .ack, .req);
	always @(posedge pclk) begin
		if (bus_hold && !hold_p) rises++;
		hold_p = bus_hold;
		if (terminal_count === 1'b1) tcs++;
		if (strobes.mem_wr) begin
			wrc++;
			wa = dma_addr;
		end
		if (strobes.mem_rd) ra = dma_addr;
		if (strobes.io_wr) iow++;
		if (strobes.mem_rd || strobes.io_rd) run++;
		else if (run > 0) begin
			rdl = run;
			run = 0;
		end
		for (int i = 3; i >= 0; i--)
			if (first < 0 && ack[i] === ackh) first = i;
	end
	task chk(string n, logic [31:0] x, logic [31:0] g);
		compares++;
		if (g !== x) begin
			fails++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
		if (n >= 40) chk("pready", 1, 0);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rd(logic [7:0] a, logic [31:0] x, string n);
		apb(0, a, 0);
		chk(n, x, r);
	endtask
	task unm(int c);
		msk &= ~(1 << c);
		apb(1, OFS_MASK, msk);
	endtask
	task prog(int c, int a, int n);
		apb(1, 8'(32 + 4 * c), a);
		apb(1, 8'(48 + 4 * c), n);
		ca[c] = a; ba[c] = a; cc[c] = n; bc[c] = n;
	endtask
	task cmp_ch(int c);
		rd(8'(32 + 4 * c), ca[c], "cur addr");
		rd(8'(48 + 4 * c), cc[c], "cur count");
	endtask
	task xf(int c, int n, bit dec, bit au);
		repeat (n) begin
			ca[c] = (dec ? ca[c] - 1 : ca[c] + 1) & 'hFFFF;
			if (cc[c] == 0 && au) begin
				ca[c] = ba[c];
				cc[c] = bc[c] + 1;
			end else if (cc[c] == 0) msk |= 1 << c;
			cc[c] = (cc[c] - 1) & 'hFFFF;
		end
	endtask
	task quiet;
		int n, q;
		n = 0;
		q = 0;
		while (q < 12 && n < 3000) begin
			@(posedge pclk);
			n++;
			q = bus_hold ? 0 : q + 1;
		end
		if (n >= 3000) chk("idle", 1, 0);
	endtask
	task zero;
		rises = 0; tcs = 0; wrc = 0; first = -1;
		iow = 0;
	endtask
	// One single-byte request on each channel in s at once
	task burst(logic [3:0] s, int exp);
		for (int c = 0; c < 4; c++)
			if (s[c]) prog(c, 'h40 * (c + 1), 0);
		for (int c = 0; c < 4; c++)
			if (s[c]) unm(c);
		zero();
		shot <= s;
		@(posedge pclk) shot <= 0;
		quiet();
		for (int c = 0; c < 4; c++)
			if (s[c]) xf(c, 1, 0, 0);
		chk("first ack", exp, first);
	endtask
	task print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge pclk);
		chk("watchdog", 1, 0);
		print_verdict();
	end
	initial begin
		void'($urandom(32'hA08F));
		repeat (6) @(posedge pclk);
		presetn <= 1;
		mem_rdata <= 8'($urandom);
		@(posedge pclk);
		chk("ack idle", 4'hF, ack);
		rd(OFS_MASK, 15, "mask");
		apb(0, OFS_CMD, 0);
		chk("cmd read err", 1, e);
		apb(0, 8'hFC, 0);
		chk("unmapped err", 1, e);
		$display("test reset done");
		prog(2, $urandom & 'hFFFF, 2);
		apb(1, OFS_MODE, 'h4A);
		unm(2);
		zero();
		want[2] <= 1;
		quiet();
		want[2] <= 0;
		xf(2, 3, 0, 0);
		chk("bus grants", 3, rises);
		chk("tc pulses", 1, tcs);
		chk("mem writes", 0, wrc);
		chk("read len", 4, rdl);
		cmp_ch(2);
		rd(OFS_MASK, msk, "mask");
		rd(OFS_STATUS, 4, "status");
		rd(OFS_STATUS, 0, "status");
		$display("test single done");
		prog(1, 'h100, 3);
		apb(1, OFS_MODE, 'hB5);
		unm(1);
		zero();
		shot <= 4'h2;
		@(posedge pclk) shot <= 0;
		quiet();
		xf(1, 4, 1, 1);
		chk("bus grants", 1, rises);
		chk("tc pulses", 1, tcs);
		chk("mem writes", 4, wrc);
		cmp_ch(1);
		rd(OFS_MASK, msk, "mask");
		$display("test block done");
		apb(1, OFS_MODE, 'h40);
		apb(1, OFS_MODE, 'h43);
		burst(4'h9, 0);
		chk("mem writes", 0, wrc);
		apb(1, OFS_CMD, 'h10);
		burst(4'h1, 0);
		burst(4'h9, 3);
		rd(OFS_MASK, msk, "mask");
		$display("test priority done");
		apb(1, OFS_CMD, 'h04);
		prog(0, 'h77, 0);
		unm(0);
		zero();
		shot <= 4'h1;
		@(posedge pclk) shot <= 0;
		repeat (30) @(posedge pclk);
		chk("bus grants", 0, rises);
		apb(1, OFS_CMD, 0);
		quiet();
		xf(0, 1, 0, 0);
		chk("bus grants", 1, rises);
		cmp_ch(0);
		$display("test disable done");
		msk = 15;
		apb(1, OFS_MASK, 15);
		apb(1, OFS_CMD, 'hE8);
		reql <= 1;
		ackh <= 1;
		repeat (3) @(posedge pclk);
		chk("ack idle", 0, ack);
		apb(1, OFS_MODE, 'h44);
		burst(4'h1, 0);
		chk("read len", 2, rdl);
		chk("mem writes", 2, wrc);
		$display("test timing done");
		apb(1, OFS_MCLR, 0);
		reql <= 0;
		ackh <= 0;
		repeat (3) @(posedge pclk);
		chk("ack idle", 4'hF, ack);
		rd(OFS_MASK, 15, "mask");
		$display("test clear done");
		prog(0, 'h300, 5);
		prog(1, 'h500, 2);
		apb(1, OFS_MODE, 'h81);
		apb(1, OFS_CMD, 'h03);
		unm(0);
		zero();
		want[0] <= 1;
		@(posedge pclk) want[0] <= 0;
		quiet();
		xf(1, 3, 0, 0);
		chk("bus grants", 1, rises);
		chk("tc pulses", 1, tcs);
		chk("mem writes", 3, wrc);
		chk("first ack", -1, first);
		chk("write addr", 'h502, wa);
		chk("read addr", 'h300, ra);
		chk("write data", mem_rdata, mem_wdata);
		rd(OFS_TEMP, mem_rdata, "temp");
		cmp_ch(0);
		cmp_ch(1);
		rd(OFS_STATUS, 2, "status");
		$display("test copy done");
		apb(1, OFS_CMD, 0);
		apb(1, OFS_MODE, 'h0B);
		prog(3, 'h80, 'h30);
		unm(3);
		zero();
		want[3] <= 1;
		repeat (20) @(posedge pclk);
		want[3] <= 0;
		quiet();
		want[3] <= 1;
		repeat (10) @(posedge pclk);
		eopn <= 0;
		@(posedge pclk) eopn <= 1;
		quiet();
		want[3] <= 0;
		xf(3, iow, 0, 0);
		msk |= 8;
		chk("bus grants", 2, rises);
		chk("tc pulses", 0, tcs);
		cmp_ch(3);
		rd(OFS_MASK, msk, "mask");
		rd(OFS_STATUS, 8, "status");
		$display("test demand done");
		print_verdict();
	end
endmodule
